// *** scpt_pkg.sv ***
// package for the system clock prescaler and oscillator trim block
package scpt_pkg;
  localparam logic [31:0] SCPT_OFS_TRIM      = 32'h0000_0000;
  localparam logic [31:0] SCPT_OFS_DIVCTL    = 32'h0000_0004;
  localparam int          SCPT_UNLOCK_BIT    = 7;
  localparam logic [2:0]  SCPT_UNLOCK_CYCLES = 3'h4;
  localparam logic [3:0]  SCPT_DIV_RST_FAST  = 4'h0;
  localparam logic [3:0]  SCPT_DIV_RST_SLOW  = 4'h3;
  localparam logic [3:0]  SCPT_DIV_MAX_CODE  = 4'h8;
  localparam int          SCPT_CNT_W         = 8;
  localparam logic [7:0]  SCPT_TRIM_RST      = 8'h80;

  typedef struct packed {
    logic       unlock;
    logic [3:0] sel;
  } scpt_divctl_s;

  typedef struct packed {
    logic       range;
    logic [6:0] tune;
  } scpt_trim_s;

  typedef struct packed {
    logic        cpu;
    logic        io;
    logic        adc;
    logic        flash;
  } scpt_clk_s;
endpackage : scpt_pkg

// *** scpt_divider.sv ***
// glitch-free power-of-two clock divider with safe switch-over
`timescale 1ns/10ps
module scpt_divider (
  input  wire logic       clk_sys_in,   // undivided master clock
  input  wire logic       rst_in,       // async reset, active high
  input  wire logic [3:0] sel_in,       // requested divide select, adopted at the next switch point
  input  wire logic [3:0] rst_sel_in,   // divide select used at reset
  output logic            clk_div_out,  // divided clock, registered; gated master clock at factor one
  output logic            edge_out      // pulse: next master edge rises the divided clock
);
  import scpt_pkg::*;

  logic [SCPT_CNT_W-1:0] cnt_ff;
  logic [3:0]            cur_sel_ff;
  logic                  div_ff;
  logic                  byp_ff;
  logic                  run_ff;
  logic                  wrap;
  logic                  switch_pt;
  logic                  sel_chg;
  logic [SCPT_CNT_W-1:0] half;

  function automatic logic [SCPT_CNT_W-1:0] half_of(input logic [3:0] s);
    if (s == 4'h0)
      half_of = '0;
    else
      half_of = SCPT_CNT_W'((9'h001 << s) >> 1) - SCPT_CNT_W'(1);
  endfunction : half_of

  assign half = half_of(cur_sel_ff);
  assign wrap = (cnt_ff == half);
  // bypass may leave on any master edge; divided mode only after a full low-then-high period
  assign switch_pt = byp_ff | (wrap & div_ff);
  assign sel_chg   = run_ff & (sel_in != cur_sel_ff);

  // half-period counter; held at zero while the master clock is passed straight through
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
    end else if (byp_ff || wrap) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + SCPT_CNT_W'(1);
    end
  end

  // new factor adopted only at end of a full old period, so no short pulse [RULE_03]
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cur_sel_ff <= SCPT_DIV_RST_FAST;
      byp_ff     <= 1'b1;
      run_ff     <= 1'b0;
    end else if (!run_ff) begin
      run_ff     <= 1'b1;
      cur_sel_ff <= rst_sel_in;
      byp_ff     <= (rst_sel_in == 4'h0);
    end else if (switch_pt && sel_chg) begin
      cur_sel_ff <= sel_in; // [RULE_04] [RULE_05]
      byp_ff     <= (sel_in == 4'h0);
    end
  end

  // divided clock toggles on each half period, giving a 50 percent duty clock [RULE_06]
  // leaving bypass starts the high half at the same rising master edge
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      div_ff <= 1'b0;
    end else if (byp_ff) begin
      div_ff <= sel_chg & (sel_in != 4'h0);
    end else if (wrap) begin
      div_ff <= ~div_ff;
    end
  end

  // factor one passes the master clock; mode only flips at a rising master edge, with the newly selected source high [RULE_03]
  assign clk_div_out = byp_ff ? (clk_sys_in & run_ff) : div_ff;
  assign edge_out    = byp_ff | (wrap & ~div_ff);
endmodule : scpt_divider

// *** scpt_top.sv ***
// top of the system clock prescaler and oscillator trim block with AHB-Lite slave
`timescale 1ns/10ps
// Functional notes
// [RULE_01] one divided clock drives cpu, io, adc and flash clocks together
// [RULE_02] select 0000..1000 maps to factor 1..256; 1001..1111 reserved
// [RULE_03] divider switch-over produces no glitch nor faster intermediate period
// [RULE_04] new rate active between T1+T2 and T1+2*T2 after the write
// [RULE_05] two active edges appear during the transition interval
// [RULE_06] divider runs on master clock; its count is not readable
// [RULE_07] unlock bit sets only on write of 0x80 exactly
// [RULE_08] unlock clears four cycles after set, or when select is written
// [RULE_09] rewriting unlock in its window neither restarts nor clears it
// [RULE_10] software writes unlock, then select within four cycles
// [RULE_11] software keeps interrupts off across the unlock sequence
// [RULE_12] reset select is 0000, or 0011 when divide-by-eight fuse programmed
// [RULE_13] any select value accepted through unlock, fuse notwithstanding
// [RULE_14] divider register bits 6 to 4 read as zero
// [RULE_15] reset loads trim with factory calibration value; software may rewrite
// [RULE_16] trim bit 7 picks low or high oscillator range
// [RULE_17] trim bits 6..0 tune monotonically within the range
// [RULE_18] software should not trim above 8.8 MHz when writing nvm
// [RULE_19] select write without unlock is ignored
module scpt_top #(
  parameter logic [7:0] FACTORY_TRIM = 8'h80  // factory calibration image
) (
  input  wire logic             clk_sys_in,     // undivided master clock
  input  wire logic             rst_in,         // async reset, active high
  input  wire logic             div8_fuse_in,   // divide-by-eight fuse, 1 = programmed
  input  wire logic             hsel_in,        // AHB slave select
  input  wire logic [31:0]      haddr_in,       // AHB address
  input  wire logic [1:0]       htrans_in,      // AHB transfer type
  input  wire logic             hwrite_in,      // AHB write
  input  wire logic [2:0]       hsize_in,       // AHB size
  input  wire logic [31:0]      hwdata_in,      // AHB write data
  input  wire logic             hready_in,      // AHB bus ready
  output logic [31:0]           hrdata_out,     // AHB read data
  output logic                  hreadyout_out,  // AHB slave ready
  output logic                  hresp_out,      // AHB response, always OKAY
  output scpt_pkg::scpt_clk_s   clk_out,        // divided domain clocks
  output scpt_pkg::scpt_trim_s  trim_out,       // oscillator trim setting
  output logic [3:0]            divide_select_out // programmed divide select, reserved codes not clamped
);
  import scpt_pkg::*;

  logic         wr_pend_ff;
  logic [31:0]  addr_ff;
  logic         fuse_ff;
  logic         strap_done_ff;
  scpt_divctl_s ctl_ff;
  logic [2:0]   unl_cnt_ff;
  scpt_trim_s   trim_ff;
  logic         clk_div;
  logic         div_edge;
  logic         wr_ctl;
  logic         wr_trim;
  logic [7:0]   wbyte;
  logic [31:0]  nxt_rdata;
  logic [31:0]  rdata_ff;

  function automatic logic is_addr(input logic [31:0] a, input logic [31:0] ofs);
    is_addr = (a[7:2] == ofs[7:2]);
  endfunction : is_addr

  // AHB address phase capture; slave answers with zero wait states
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_ff <= 1'b0;
      addr_ff    <= '0;
    end else if (hready_in) begin
      wr_pend_ff <= hsel_in & htrans_in[1] & hwrite_in;
      addr_ff    <= haddr_in;
    end
  end

  assign wbyte   = hwdata_in[7:0];
  assign wr_ctl  = wr_pend_ff & is_addr(addr_ff, SCPT_OFS_DIVCTL);
  assign wr_trim = wr_pend_ff & is_addr(addr_ff, SCPT_OFS_TRIM);

  // read data registered at the address phase
  always_comb begin
    nxt_rdata = '0;
    if (is_addr(haddr_in, SCPT_OFS_DIVCTL))
      nxt_rdata = {24'h0, ctl_ff.unlock, 3'h0, ctl_ff.sel}; // [RULE_14] [RULE_06]
    else if (is_addr(haddr_in, SCPT_OFS_TRIM))
      nxt_rdata = {24'h0, trim_ff};
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff <= '0;
    end else if (hready_in & hsel_in & htrans_in[1] & ~hwrite_in) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign hrdata_out    = rdata_ff;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // fuse sampled at first clock after reset release
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      strap_done_ff <= 1'b0;
      fuse_ff       <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      fuse_ff       <= div8_fuse_in;
    end
  end

  // unlock bit: set only by exact 0x80, timed close, closed by select write
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_ff.unlock <= 1'b0;
      unl_cnt_ff    <= '0;
    end else if (ctl_ff.unlock) begin
      if (wr_ctl && !wbyte[SCPT_UNLOCK_BIT]) begin
        ctl_ff.unlock <= 1'b0; // [RULE_08]
      end else if (unl_cnt_ff == SCPT_UNLOCK_CYCLES - 3'h1) begin
        ctl_ff.unlock <= 1'b0; // [RULE_08] rewrite does not restart [RULE_09]
      end
      unl_cnt_ff <= unl_cnt_ff + 3'h1;
    end else if (wr_ctl && wbyte == 8'h80) begin
      ctl_ff.unlock <= 1'b1; // [RULE_07]
      unl_cnt_ff    <= '0;
    end
  end

  // divide select: strap after reset, then only through unlock
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_ff.sel <= SCPT_DIV_RST_FAST;
    end else if (!strap_done_ff) begin
      ctl_ff.sel <= div8_fuse_in ? SCPT_DIV_RST_SLOW : SCPT_DIV_RST_FAST; // [RULE_12]
    end else if (wr_ctl && ctl_ff.unlock && !wbyte[SCPT_UNLOCK_BIT]) begin
      ctl_ff.sel <= wbyte[3:0]; // [RULE_13] [RULE_19]
    end
  end

  // trim register: factory value at first clock after reset, software writable
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      trim_ff <= SCPT_TRIM_RST; // [RULE_15]
    end else if (!strap_done_ff) begin
      trim_ff <= FACTORY_TRIM; // [RULE_15]
    end else if (wr_trim) begin
      trim_ff <= wbyte; // [RULE_16] [RULE_17]
    end
  end

  logic [3:0] eff_sel;
  // reserved codes fall back to the largest factor [RULE_02]
  assign eff_sel = (ctl_ff.sel > SCPT_DIV_MAX_CODE) ? SCPT_DIV_MAX_CODE : ctl_ff.sel;

  scpt_divider u_div (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .sel_in      (eff_sel),
    .rst_sel_in  (SCPT_DIV_RST_FAST),
    .clk_div_out (clk_div),
    .edge_out    (div_edge)
  );

  // one divided clock shared by every synchronous domain [RULE_01]
  assign clk_out.cpu   = clk_div;
  assign clk_out.io    = clk_div;
  assign clk_out.adc   = clk_div;
  assign clk_out.flash = clk_div;
  assign trim_out          = trim_ff;
  assign divide_select_out = ctl_ff.sel;

  // unlock closes within four cycles of being set
  property p_unlock_closes;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(ctl_ff.unlock) |-> ##[1:4] !ctl_ff.unlock;
  endproperty
  a_unlock_closes: assert property (p_unlock_closes) else $error("unlock open too long"); // [RULE_08]

  property p_unlock_only_exact;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(ctl_ff.unlock) |-> $past(wr_ctl) && $past(wbyte) == 8'h80;
  endproperty
  a_unlock_only_exact: assert property (p_unlock_only_exact) else $error("bad unlock set"); // [RULE_07]

  property p_sel_locked;
    @(posedge clk_sys_in) disable iff (rst_in)
      strap_done_ff && !ctl_ff.unlock |=> $stable(ctl_ff.sel);
  endproperty
  a_sel_locked: assert property (p_sel_locked) else $error("select changed while locked"); // [RULE_19]

  property p_sel_write_closes;
    @(posedge clk_sys_in) disable iff (rst_in)
      ctl_ff.unlock && wr_ctl && !wbyte[7] |=> !ctl_ff.unlock && ctl_ff.sel == $past(wbyte[3:0]);
  endproperty
  a_sel_write_closes: assert property (p_sel_write_closes) else $error("select write failed"); // [RULE_08]

  property p_no_restart;
    @(posedge clk_sys_in) disable iff (rst_in)
      ctl_ff.unlock && wr_ctl && wbyte == 8'h80 |=> $past(unl_cnt_ff) + 3'h1 == unl_cnt_ff;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("unlock timeout restarted"); // [RULE_09]

  property p_reserved_zero;
    @(posedge clk_sys_in) disable iff (rst_in)
      hready_in && hsel_in && htrans_in[1] && is_addr(haddr_in, SCPT_OFS_DIVCTL)
      |=> hrdata_out[6:4] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [RULE_14]

  property p_strap;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(strap_done_ff) |-> ctl_ff.sel == (fuse_ff ? SCPT_DIV_RST_SLOW : SCPT_DIV_RST_FAST);
  endproperty
  a_strap: assert property (p_strap) else $error("reset select wrong"); // [RULE_12]

  property p_trim_write;
    @(posedge clk_sys_in) disable iff (rst_in)
      strap_done_ff && wr_trim |=> trim_ff == $past(wbyte);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost"); // [RULE_15]

  property p_clocks_equal;
    @(posedge clk_sys_in) disable iff (rst_in)
      clk_out.cpu == clk_out.io && clk_out.adc == clk_out.flash && clk_out.io == clk_out.adc;
  endproperty
  a_clocks_equal: assert property (p_clocks_equal) else $error("domain clocks differ"); // [RULE_01]

  property p_trim_reset;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(strap_done_ff) |-> trim_ff == FACTORY_TRIM;
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim reset value wrong"); // [RULE_15]

  property p_fuse_sample;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(strap_done_ff) |-> fuse_ff == $past(div8_fuse_in);
  endproperty
  a_fuse_sample: assert property (p_fuse_sample) else $error("fuse not sampled"); // [RULE_12]

  property p_unlock_cnt_bound;
    @(posedge clk_sys_in) disable iff (rst_in)
      ctl_ff.unlock |-> unl_cnt_ff < SCPT_UNLOCK_CYCLES;
  endproperty
  a_unlock_cnt_bound: assert property (p_unlock_cnt_bound) else $error("unlock count high"); // [RULE_08]

  property p_timeout;
    @(posedge clk_sys_in) disable iff (rst_in)
      ctl_ff.unlock && unl_cnt_ff == SCPT_UNLOCK_CYCLES - 3'h1 |=> !ctl_ff.unlock;
  endproperty
  a_timeout: assert property (p_timeout) else $error("unlock did not time out"); // [RULE_08]

  property p_bad_unlock;
    @(posedge clk_sys_in) disable iff (rst_in)
      !ctl_ff.unlock && wr_ctl && wbyte != 8'h80 |=> !ctl_ff.unlock;
  endproperty
  a_bad_unlock: assert property (p_bad_unlock) else $error("unlock set by bad write"); // [RULE_07]

  property p_unlock_sets;
    @(posedge clk_sys_in) disable iff (rst_in)
      !ctl_ff.unlock && wr_ctl && wbyte == 8'h80 |=> ctl_ff.unlock && unl_cnt_ff == '0;
  endproperty
  a_unlock_sets: assert property (p_unlock_sets) else $error("unlock not set"); // [RULE_07]

  property p_rewrite_keeps;
    @(posedge clk_sys_in) disable iff (rst_in)
      ctl_ff.unlock && wr_ctl && wbyte[SCPT_UNLOCK_BIT]
      && unl_cnt_ff != SCPT_UNLOCK_CYCLES - 3'h1 |=> ctl_ff.unlock;
  endproperty
  a_rewrite_keeps: assert property (p_rewrite_keeps) else $error("rewrite cleared unlock"); // [RULE_09]

  property p_eff_range;
    @(posedge clk_sys_in) disable iff (rst_in)
      eff_sel <= SCPT_DIV_MAX_CODE;
  endproperty
  a_eff_range: assert property (p_eff_range) else $error("divider select out of range"); // [RULE_02]

  property p_reserved_slowest;
    @(posedge clk_sys_in) disable iff (rst_in)
      ctl_ff.sel > SCPT_DIV_MAX_CODE |-> eff_sel == SCPT_DIV_MAX_CODE;
  endproperty
  a_reserved_slowest: assert property (p_reserved_slowest) else $error("reserved code"); // [RULE_02]

  property p_rdata_divctl;
    @(posedge clk_sys_in) disable iff (rst_in)
      hready_in && hsel_in && htrans_in[1] && !hwrite_in && is_addr(haddr_in, SCPT_OFS_DIVCTL)
      |=> hrdata_out == {24'h0, $past(ctl_ff.unlock), 3'h0, $past(ctl_ff.sel)};
  endproperty
  a_rdata_divctl: assert property (p_rdata_divctl) else $error("divider read wrong"); // [RULE_14]

  property p_rdata_trim;
    @(posedge clk_sys_in) disable iff (rst_in)
      hready_in && hsel_in && htrans_in[1] && !hwrite_in && is_addr(haddr_in, SCPT_OFS_TRIM)
      |=> hrdata_out == {24'h0, $past(trim_ff)};
  endproperty
  a_rdata_trim: assert property (p_rdata_trim) else $error("trim read wrong"); // [RULE_15]

  property p_rdata_unmapped;
    @(posedge clk_sys_in) disable iff (rst_in)
      hready_in && hsel_in && htrans_in[1] && !hwrite_in
      && !is_addr(haddr_in, SCPT_OFS_TRIM) && !is_addr(haddr_in, SCPT_OFS_DIVCTL)
      |=> hrdata_out == 32'h0;
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read"); // [RULE_06]

  property p_rdata_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      !(hready_in && hsel_in && htrans_in[1] && !hwrite_in) |=> $stable(hrdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // [RULE_14]

  property p_trim_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      strap_done_ff && !wr_trim |=> $stable(trim_ff);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim changed unasked"); // [RULE_15]

  property p_wr_capture;
    @(posedge clk_sys_in) disable iff (rst_in)
      hready_in && hsel_in && htrans_in[1] && hwrite_in |=> wr_pend_ff;
  endproperty
  a_wr_capture: assert property (p_wr_capture) else $error("write not captured"); // [RULE_07]

  property p_ctl_no_trim;
    @(posedge clk_sys_in) disable iff (rst_in)
      strap_done_ff && wr_ctl |=> $stable(trim_ff);
  endproperty
  a_ctl_no_trim: assert property (p_ctl_no_trim) else $error("divider write hit trim"); // [RULE_15]

  property p_sel_cause;
    @(posedge clk_sys_in) disable iff (rst_in)
      $past(strap_done_ff) && $changed(ctl_ff.sel) |-> $past(ctl_ff.unlock) && $past(wr_ctl);
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("select changed unasked"); // [RULE_19]

  c_unlock: cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(ctl_ff.unlock));
  c_change: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    strap_done_ff && $changed(ctl_ff.sel));
  c_timeout: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    $fell(ctl_ff.unlock) && !$past(wr_ctl));
  c_edge: cover property (@(posedge clk_sys_in) disable iff (rst_in) div_edge && eff_sel == 4'h8);
  c_bypass: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    strap_done_ff && $changed(eff_sel) && eff_sel == 4'h0);
endmodule : scpt_top

// *** test_system_clock_prescaler_trim.sv ***
// self-checking testbench for the clock prescaler and oscillator trim block
`timescale 1ns/10ps
module test_system_clock_prescaler_trim;
  import scpt_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst;
  logic        fuse;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  scpt_clk_s   clk;
  scpt_trim_s  trim;
  logic [3:0]  dsel;
  int          n_fail = 0;
  int          checks = 0;
  int          fac = 8;

  // one slave on the bus: its ready is the bus ready
  assign hready = hreadyout;

  scpt_top #(.FACTORY_TRIM(8'h80)) scpt_top_inst (
    .clk_sys_in(clk_sys), .rst_in(rst), .div8_fuse_in(fuse), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .clk_out(clk), .trim_out(trim),
    .divide_select_out(dsel));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic final_report;
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_per(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: period %0h expected %0h", $time, got, exp);
    end
  endtask : check_per

  // single AHB transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check_val(r, e);
  endtask : rd_chk

  // divided period in master cycles; ends just after a master edge
  task automatic period(output logic [31:0] p);
    realtime t;
    @(posedge clk.cpu);
    t = $realtime;
    @(posedge clk.cpu);
    p = 32'(int'(($realtime - t) / 10.0));
    #1 check_val({28'h0, clk}, {28'h0, {4{clk.cpu}}});
    @(posedge clk_sys);
  endtask : period

  task automatic switch_to(input logic [3:0] code);
    realtime     t0;
    logic [31:0] p;
    int          nf;
    int          lim;
    nf  = (code > SCPT_DIV_MAX_CODE) ? 256 : (1 << code);
    lim = (nf < fac) ? nf : fac;
    wr(SCPT_OFS_DIVCTL, 32'h80);
    wr(SCPT_OFS_DIVCTL, {28'h0, code});
    t0 = $realtime;
    while ($realtime - t0 < 10.0 * (fac + 2 * nf)) begin
      period(p);
      check_val(32'(p >= lim), 32'h1);
    end
    period(p);
    check_per(p, 32'(nf));
    rd_chk(SCPT_OFS_DIVCTL, {28'h0, code});
    check_val({28'h0, dsel}, {28'h0, code});
    fac = nf;
  endtask : switch_to

  task automatic do_reset(input logic f);
    rst  <= 1'b1;
    fuse <= f;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : do_reset

  task automatic s_locked;
    wr(SCPT_OFS_DIVCTL, 32'h05);
    rd_chk(SCPT_OFS_DIVCTL, 32'h03);
    wr(SCPT_OFS_DIVCTL, 32'h81);
    wr(SCPT_OFS_DIVCTL, 32'h05);
    rd_chk(SCPT_OFS_DIVCTL, 32'h03);
    wr(32'h08, 32'hFF);
    rd_chk(32'h08, 32'h0);
    rd_chk(SCPT_OFS_TRIM, 32'h80);
  endtask : s_locked

  task automatic s_unlock;
    wr(SCPT_OFS_DIVCTL, 32'h80);
    wr(SCPT_OFS_DIVCTL, 32'h72);
    wr(SCPT_OFS_DIVCTL, 32'h04);
    rd_chk(SCPT_OFS_DIVCTL, 32'h02);
    wr(SCPT_OFS_DIVCTL, 32'h80);
    rd_chk(SCPT_OFS_DIVCTL, 32'h82);
    repeat (2) @(posedge clk_sys);
    rd_chk(SCPT_OFS_DIVCTL, 32'h02);
    wr(SCPT_OFS_DIVCTL, 32'h05);
    rd_chk(SCPT_OFS_DIVCTL, 32'h02);
    wr(SCPT_OFS_DIVCTL, 32'h80);
    wr(SCPT_OFS_DIVCTL, 32'h80);
    @(posedge clk_sys);
    wr(SCPT_OFS_DIVCTL, 32'h05);
    rd_chk(SCPT_OFS_DIVCTL, 32'h02);
    wr(SCPT_OFS_DIVCTL, 32'h80);
    @(posedge clk_sys);
    wr(SCPT_OFS_DIVCTL, 32'h01);
    rd_chk(SCPT_OFS_DIVCTL, 32'h01);
  endtask : s_unlock

  task automatic s_trim;
    logic [7:0] v [3] = '{8'h7F, 8'h00, 8'hA5};
    foreach (v[i]) begin
      wr(SCPT_OFS_TRIM, {24'h0, v[i]});
      rd_chk(SCPT_OFS_TRIM, {24'h0, v[i]});
      check_val({24'h0, trim}, {24'h0, v[i]});
    end
  endtask : s_trim

  initial begin
    logic [31:0] p;
    rst    = 1'b1;
    fuse   = 1'b1;
    hsel   = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize  = 3'h2;
    haddr  = 32'h0;
    hwdata = 32'h0;
    do_reset(1'b1);
    rd_chk(SCPT_OFS_DIVCTL, 32'h03);
    rd_chk(SCPT_OFS_TRIM, 32'h80);
    period(p);
    check_per(p, 32'h8);
    s_locked();
    for (int c = 0; c < 10; c++) switch_to(4'(c));
    s_unlock();
    s_trim();
    do_reset(1'b0);
    rd_chk(SCPT_OFS_DIVCTL, 32'h00);
    rd_chk(SCPT_OFS_TRIM, 32'h80);
    check_val({28'h0, dsel}, 32'h0);
    period(p);
    check_per(p, 32'h1);
    final_report();
  end

  // the whole run needs well under a fifth of this span
  initial begin
    #500us;
    n_fail++;
    final_report();
  end
endmodule : test_system_clock_prescaler_trim
